// ==== shared/eirq_pkg.sv ====
// Constants for the external request capture block.
package eirq_pkg;
   // ==================================================
   // Register addresses and pages
   localparam logic [7:0] EIRQ_CFG_ADDR = 8'he4;
   localparam logic [7:0] EIRQ_CFG_PAGE = 8'h0f;
   localparam logic [7:0] EIRQ_PRIO2_ADDR = 8'hf7;
   localparam logic [7:0] EIRQ_TCTL_ADDR = 8'h88;
   // ==================================================
   // Reset values
   localparam logic [7:0] EIRQ_CFG_RST = 8'h00;
   localparam logic [7:0] EIRQ_PRIO2_RST = 8'h00;
   localparam logic [1:0] EIRQ_MODE_RST = 2'h0;
   // ==================================================
   // Configuration register fields
   localparam int EIRQ_B_POL_BIT = 7;
   localparam int EIRQ_B_SEL_LSB = 4;
   localparam int EIRQ_A_POL_BIT = 3;
   localparam int EIRQ_A_SEL_LSB = 0;
   localparam int EIRQ_SEL_W = 3;
   // ==================================================
   // Timer control register fields
   localparam int EIRQ_A_EDGE_BIT = 0;
   localparam int EIRQ_A_PEND_BIT = 1;
   localparam int EIRQ_B_EDGE_BIT = 2;
   localparam int EIRQ_B_PEND_BIT = 3;
   // ==================================================
   // Second priority register fields
   localparam int EIRQ_PT5_BIT = 7;
   localparam int EIRQ_PT4_BIT = 6;
   localparam int EIRQ_PCMP_BIT = 5;
   localparam int EIRQ_PCA1_BIT = 4;
   localparam int EIRQ_PSER1_BIT = 3;
   localparam int EIRQ_PMATCH_BIT = 2;
   localparam int EIRQ_PCAN_BIT = 1;
   localparam int EIRQ_PREG_BIT = 0;
endpackage

// ==== shared/eirq_if.sv ====
// Link between the register block and one request detector.
`timescale 1ns/10ps
interface eirq_if;
   logic level;
   logic polarity;
   logic edge_mode;
   logic ack;
   logic wr_en;
   logic wr_val;
   logic pending;
   modport ctl (output level, output polarity, output edge_mode, output ack,
      output wr_en, output wr_val, input pending);
   modport det (input level, input polarity, input edge_mode, input ack,
      input wr_en, input wr_val, output pending);
endinterface

// ==== rtl/eirq_detect.sv ====
// Pending flag logic for one external request input.
`timescale 1ns/10ps
module eirq_detect
   import eirq_pkg::*;
(
   input wire logic mclk,
   input wire logic nrst,
   eirq_if.det ch
);
   logic active;
   logic prev_active;

   // ==================================================
   // Active level and edge history.
   assign active = ~(ch.level ^ ch.polarity);

   // Previous level starts as active so that reset never looks like an edge.
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         prev_active <= 1'b1;
      end
      else
      begin
         prev_active <= active;
      end
   end

   // ==================================================
   // Pending flag; a fresh edge wins over any clear.
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         ch.pending <= 1'b0;
      end
      else if (!ch.edge_mode)
      begin
         ch.pending <= active;
      end
      else if (active && !prev_active)
      begin
         ch.pending <= 1'b1;
      end
      else if (ch.ack)
      begin
         ch.pending <= 1'b0;
      end
      else if (ch.wr_en)
      begin
         ch.pending <= ch.wr_val;
      end
   end

   // ==================================================
   // Checks.
   level_follow_a: assert property (@(posedge mclk) disable iff (!nrst)
      !ch.edge_mode |=> ch.pending == $past(active))
      else $error("level mode flag does not follow the input");
   edge_set_a: assert property (@(posedge mclk) disable iff (!nrst)
      ch.edge_mode && active && !prev_active |=> ch.pending)
      else $error("edge did not set the pending flag");
   ack_clear_a: assert property (@(posedge mclk) disable iff (!nrst)
      ch.edge_mode && ch.ack && !(active && !prev_active) |=> !ch.pending)
      else $error("vector acknowledge did not clear the flag");
   edge_hold_a: assert property (@(posedge mclk) disable iff (!nrst)
      ch.edge_mode && $past(ch.edge_mode) && !ch.ack && !ch.wr_en && !(active && !prev_active)
      |=> ch.pending == $past(ch.pending))
      else $error("edge mode flag changed without cause");
   edge_seen_c: cover property (@(posedge mclk) disable iff (!nrst)
      ch.edge_mode && active && !prev_active ##1 ch.ack ##1 !ch.pending);
   level_seen_c: cover property (@(posedge mclk) disable iff (!nrst)
      !ch.edge_mode && active ##1 ch.pending);
endmodule

// ==== rtl/eirq_top.sv ====
// Register block, pin routing and pending flags for two external requests.
`timescale 1ns/10ps

//
// Contract
// - Priority-two register at 0xF7, all pages, zero reset.
// - Priority bits map to eight named sources.
// - Polarity bit: zero low, one high.
// - Edge-mode bit: one edge, zero level.
// - Pin select codes route port-one pins 0-7.
// - Pin monitoring never disturbs the pin.
// - Pending flags at timer control bits 1, 3.
// - Edge flag clears when processor vectors.
// - Level flag mirrors active input level.
// - Config register 0xE4, page 0x0F, zero reset.
// - Config layout: polarities 7,3; selects 6:4,2:0.
module eirq_top
   import eirq_pkg::*;
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [7:0] p1_pin,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_page,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   input wire logic vec_ack_a,
   input wire logic vec_ack_b,
   output logic ext_request_a,
   output logic ext_request_b,
   output logic timer_five_prio,
   output logic timer_four_prio,
   output logic comparator_prio,
   output logic counter_array_one_prio,
   output logic serial_one_prio,
   output logic port_match_prio,
   output logic can_ctrl_prio,
   output logic regulator_dropout_prio
);
   logic [7:0] pin_meta;
   logic [7:0] pin_sync;
   logic [7:0] ext_irq_pin_config;
   logic [7:0] extended_priority_two;
   logic req_a_edge_mode;
   logic req_b_edge_mode;
   logic cfg_hit;
   logic prio_hit;
   logic tctl_hit;
   logic [7:0] next_rdata;
   logic req_a_polarity;
   logic req_b_polarity;
   logic [2:0] req_a_pin_select;
   logic [2:0] req_b_pin_select;

   eirq_if ch_a ();
   eirq_if ch_b ();

   // ==================================================
   // Helpers.
   function automatic logic pin_pick(input logic [7:0] pins, input logic [2:0] sel);
      pin_pick = pins[sel];
   endfunction

   function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] want);
      addr_is = (addr == want);
   endfunction

   // ==================================================
   // Address decode.
   assign cfg_hit = addr_is(sfr_addr, EIRQ_CFG_ADDR) && addr_is(sfr_page, EIRQ_CFG_PAGE);
   assign prio_hit = addr_is(sfr_addr, EIRQ_PRIO2_ADDR);
   assign tctl_hit = addr_is(sfr_addr, EIRQ_TCTL_ADDR);

   // ==================================================
   // Pin synchronisers; pins are only sampled, never driven.
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         pin_meta <= 8'h00;
         pin_sync <= 8'h00;
      end
      else
      begin
         pin_meta <= p1_pin;
         pin_sync <= pin_meta;
      end
   end

   // ==================================================
   // Configuration register.
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         ext_irq_pin_config <= EIRQ_CFG_RST;
      end
      else if (sfr_wr && cfg_hit)
      begin
         ext_irq_pin_config <= sfr_wdata;
      end
   end

   assign req_b_polarity = ext_irq_pin_config[EIRQ_B_POL_BIT];
   assign req_b_pin_select = ext_irq_pin_config[EIRQ_B_SEL_LSB +: EIRQ_SEL_W];
   assign req_a_polarity = ext_irq_pin_config[EIRQ_A_POL_BIT];
   assign req_a_pin_select = ext_irq_pin_config[EIRQ_A_SEL_LSB +: EIRQ_SEL_W];

   // ==================================================
   // Second priority register.
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         extended_priority_two <= EIRQ_PRIO2_RST;
      end
      else if (sfr_wr && prio_hit)
      begin
         extended_priority_two <= sfr_wdata;
      end
   end

   assign timer_five_prio = extended_priority_two[EIRQ_PT5_BIT];
   assign timer_four_prio = extended_priority_two[EIRQ_PT4_BIT];
   assign comparator_prio = extended_priority_two[EIRQ_PCMP_BIT];
   assign counter_array_one_prio = extended_priority_two[EIRQ_PCA1_BIT];
   assign serial_one_prio = extended_priority_two[EIRQ_PSER1_BIT];
   assign port_match_prio = extended_priority_two[EIRQ_PMATCH_BIT];
   assign can_ctrl_prio = extended_priority_two[EIRQ_PCAN_BIT];
   assign regulator_dropout_prio = extended_priority_two[EIRQ_PREG_BIT];

   // ==================================================
   // Timer control mode bits.
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         {req_b_edge_mode, req_a_edge_mode} <= EIRQ_MODE_RST;
      end
      else if (sfr_wr && tctl_hit)
      begin
         req_a_edge_mode <= sfr_wdata[EIRQ_A_EDGE_BIT];
         req_b_edge_mode <= sfr_wdata[EIRQ_B_EDGE_BIT];
      end
   end

   // ==================================================
   // Detector channels.
   assign ch_a.level = pin_pick(pin_sync, req_a_pin_select);
   assign ch_a.polarity = req_a_polarity;
   assign ch_a.edge_mode = req_a_edge_mode;
   assign ch_a.ack = vec_ack_a;
   assign ch_a.wr_en = sfr_wr && tctl_hit;
   assign ch_a.wr_val = sfr_wdata[EIRQ_A_PEND_BIT];

   assign ch_b.level = pin_pick(pin_sync, req_b_pin_select);
   assign ch_b.polarity = req_b_polarity;
   assign ch_b.edge_mode = req_b_edge_mode;
   assign ch_b.ack = vec_ack_b;
   assign ch_b.wr_en = sfr_wr && tctl_hit;
   assign ch_b.wr_val = sfr_wdata[EIRQ_B_PEND_BIT];

   eirq_detect u_det_a
   (
      .mclk(mclk),
      .nrst(nrst),
      .ch(ch_a)
   );

   eirq_detect u_det_b
   (
      .mclk(mclk),
      .nrst(nrst),
      .ch(ch_b)
   );

   assign ext_request_a = ch_a.pending;
   assign ext_request_b = ch_b.pending;

   // ==================================================
   // Read data mux; unmapped addresses read zero.
   always_comb
   begin
      next_rdata = 8'h00;
      if (cfg_hit)
      begin
         next_rdata = ext_irq_pin_config;
      end
      else if (prio_hit)
      begin
         next_rdata = extended_priority_two;
      end
      else if (tctl_hit)
      begin
         next_rdata[EIRQ_A_EDGE_BIT] = req_a_edge_mode;
         next_rdata[EIRQ_A_PEND_BIT] = ch_a.pending;
         next_rdata[EIRQ_B_EDGE_BIT] = req_b_edge_mode;
         next_rdata[EIRQ_B_PEND_BIT] = ch_b.pending;
      end
   end

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         sfr_rdata <= 8'h00;
      end
      else if (sfr_rd)
      begin
         sfr_rdata <= next_rdata;
      end
   end

   // ==================================================
   // Checks.
   prio_write_a: assert property (@(posedge mclk) disable iff (!nrst)
      sfr_wr && addr_is(sfr_addr, EIRQ_PRIO2_ADDR) |=> extended_priority_two == $past(sfr_wdata))
      else $error("priority register write lost");

   prio_map_a: assert property (@(posedge mclk) disable iff (!nrst)
      sfr_wr && prio_hit |=> timer_five_prio == $past(sfr_wdata[7])
      && regulator_dropout_prio == $past(sfr_wdata[0])
      && port_match_prio == $past(sfr_wdata[2]))
      else $error("priority outputs do not match written bits");

   cfg_page_a: assert property (@(posedge mclk) disable iff (!nrst)
      sfr_wr && addr_is(sfr_addr, EIRQ_CFG_ADDR) && !addr_is(sfr_page, EIRQ_CFG_PAGE)
      |=> $stable(ext_irq_pin_config))
      else $error("configuration written from wrong page");

   cfg_write_a: assert property (@(posedge mclk) disable iff (!nrst)
      sfr_wr && cfg_hit |=> ext_irq_pin_config == $past(sfr_wdata))
      else $error("configuration write lost");

   pin_route_a: assert property (@(posedge mclk) disable iff (!nrst)
      $stable(ext_irq_pin_config) && $past($stable(ext_irq_pin_config))
      |-> ch_a.level == $past(p1_pin[req_a_pin_select], 2))
      else $error("request a routed from wrong pin");

   level_pol_a: assert property (@(posedge mclk) disable iff (!nrst)
      !req_b_edge_mode && $stable(req_b_polarity) && $stable(req_b_edge_mode)
      |=> ext_request_b == ($past(req_b_polarity) ? $past(ch_b.level) : !$past(ch_b.level)))
      else $error("request b polarity not applied");

   pend_read_a: assert property (@(posedge mclk) disable iff (!nrst)
      sfr_rd && tctl_hit |=> sfr_rdata[1] == $past(ext_request_a)
      && sfr_rdata[3] == $past(ext_request_b))
      else $error("pending flags read from wrong bits");

   unmapped_a: assert property (@(posedge mclk) disable iff (!nrst)
      sfr_rd && !cfg_hit && !prio_hit && !tctl_hit |=> sfr_rdata == 8'h00)
      else $error("unmapped read not zero");

   prio_cov_c: cover property (@(posedge mclk) disable iff (!nrst)
      sfr_wr && prio_hit ##1 sfr_rd && prio_hit);
   cfg_cov_c: cover property (@(posedge mclk) disable iff (!nrst)
      sfr_wr && cfg_hit && sfr_wdata[7]);
   ack_cov_c: cover property (@(posedge mclk) disable iff (!nrst)
      ext_request_b && req_b_edge_mode && vec_ack_b ##1 !ext_request_b);
endmodule

// ==== sim/eirq_src.sv ====
// Behavioural external source that drives the port-one request pins.
`timescale 1ns/10ps
module eirq_src
   import eirq_pkg::*;
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic raise,
   input wire logic [2:0] sel,
   input wire logic act,
   input wire logic [1:0] lag,
   input wire logic ack,
   output logic [7:0] p1_pin
);
   // ==================================================
   // Request hold and withdrawal
   logic held;
   logic dropping;
   logic [2:0] pin;
   logic [1:0] cnt;
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         held <= 1'b0;
         dropping <= 1'b0;
         pin <= 3'h0;
         cnt <= 2'h0;
      end
      else if (raise)
      begin
         held <= 1'b1;
         pin <= sel;
      end
      else if (ack && held && !dropping)
      begin
         dropping <= 1'b1;
         cnt <= lag;
      end
      else if (dropping)
      begin
         if (cnt == 2'h0)
         begin
            held <= 1'b0;
            dropping <= 1'b0;
         end
         else
            cnt <= cnt - 2'h1;
      end
   end
   // Only the source drives the pins, idle pins sit at the inactive level.
   assign p1_pin = {8{~act}} ^ (held ? (8'h01 << pin) : 8'h00);
endmodule

// ==== sim/testbench.sv ====
// Self-checking bench for the external request capture block.
`timescale 1ns/10ps
module testbench
   import eirq_pkg::*;
;
   // ==================================================
   // Signals
   logic mclk, nrst, sfr_wr, sfr_rd, vec_ack_a, vec_ack_b, raise, act;
   logic [7:0] sfr_addr, sfr_page, sfr_wdata, sfr_rdata, prio;
   logic [2:0] sel;
   logic [1:0] lag;
   logic ext_request_a, ext_request_b;
   wire [7:0] p1_pin;
   int mismatches = 0;
   int checked = 0;
   int cycles = 0;
   // ==================================================
   // Instances
   eirq_top i_dut (.mclk(mclk), .nrst(nrst), .p1_pin(p1_pin), .sfr_addr(sfr_addr),
      .sfr_page(sfr_page), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
      .sfr_rdata(sfr_rdata), .vec_ack_a(vec_ack_a), .vec_ack_b(vec_ack_b),
      .ext_request_a(ext_request_a), .ext_request_b(ext_request_b),
      .timer_five_prio(prio[7]), .timer_four_prio(prio[6]), .comparator_prio(prio[5]),
      .counter_array_one_prio(prio[4]), .serial_one_prio(prio[3]),
      .port_match_prio(prio[2]), .can_ctrl_prio(prio[1]),
      .regulator_dropout_prio(prio[0]));
   eirq_src i_src (.mclk(mclk), .nrst(nrst), .raise(raise), .sel(sel), .act(act),
      .lag(lag), .ack(vec_ack_a | vec_ack_b), .p1_pin(p1_pin));
   // ==================================================
   // Clock and timeout
   initial
   begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         mismatches++;
         wrap_up();
      end
   end
   // ==================================================
   // Tasks
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp)
      begin
         mismatches++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] pg, input logic [7:0] d);
      @(posedge mclk);
      sfr_addr <= a;
      sfr_page <= pg;
      sfr_wdata <= d;
      sfr_wr <= 1'b1;
      @(posedge mclk);
      sfr_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] pg, input logic [7:0] exp);
      @(posedge mclk);
      sfr_addr <= a;
      sfr_page <= pg;
      sfr_rd <= 1'b1;
      @(posedge mclk);
      sfr_rd <= 1'b0;
      #1 chk(sfr_rdata, exp);
   endtask
   task automatic pulse_ack(input logic b);
      @(posedge mclk);
      vec_ack_a <= !b;
      vec_ack_b <= b;
      @(posedge mclk);
      vec_ack_a <= 1'b0;
      vec_ack_b <= 1'b0;
   endtask
   task automatic request(input logic [2:0] s);
      @(posedge mclk);
      sel <= s;
      raise <= 1'b1;
      @(posedge mclk);
      raise <= 1'b0;
      repeat (5) @(posedge mclk);
   endtask
   task automatic setup(input logic b, input logic [2:0] s, input logic p);
      @(posedge mclk);
      act <= p;
      lag <= {b, 1'b0};
      wr(EIRQ_CFG_ADDR, EIRQ_CFG_PAGE, b ? {p, s, p, ~s} : {p, ~s, p, s});
      repeat (6) @(posedge mclk);
   endtask
   task automatic level_case(input logic b, input logic [2:0] s, input logic p);
      setup(b, s, p);
      request(s);
      #1 chk({6'h0, ext_request_b, ext_request_a}, b ? 8'h02 : 8'h01);
      rd(EIRQ_TCTL_ADDR, 8'h00, b ? 8'h08 : 8'h02);
      pulse_ack(b);
      repeat (6) @(posedge mclk);
      #1 chk({6'h0, ext_request_b, ext_request_a}, 8'h00);
   endtask
   task automatic edge_case(input logic b, input logic [2:0] s, input logic p);
      setup(b, s, p);
      wr(EIRQ_TCTL_ADDR, 8'h00, 8'h05);
      request(s);
      #1 chk({6'h0, ext_request_b, ext_request_a}, b ? 8'h02 : 8'h01);
      rd(EIRQ_TCTL_ADDR, 8'h0f, b ? 8'h0d : 8'h07);
      pulse_ack(b);
      repeat (6) @(posedge mclk);
      #1 chk({6'h0, ext_request_b, ext_request_a}, 8'h00);
      request(s);
      wr(EIRQ_TCTL_ADDR, 8'h00, 8'h05);
      repeat (4) @(posedge mclk);
      #1 chk({6'h0, ext_request_b, ext_request_a}, 8'h00);
      pulse_ack(b);
      repeat (6) @(posedge mclk);
      #1 chk({6'h0, ext_request_b, ext_request_a}, 8'h00);
   endtask
   task automatic wrap_up();
      $display("Comparisons %0d, mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // ==================================================
   // Main sequence
   initial
   begin
      nrst = 1'b0;
      {sfr_wr, sfr_rd, vec_ack_a, vec_ack_b, raise} = 5'h00;
      {sfr_addr, sfr_page, sfr_wdata} = 24'h000000;
      sel = 3'h0;
      lag = 2'h0;
      act = 1'b1;
      repeat (16) @(posedge mclk);
      nrst <= 1'b1;
      rd(EIRQ_CFG_ADDR, EIRQ_CFG_PAGE, EIRQ_CFG_RST);
      rd(EIRQ_PRIO2_ADDR, 8'h00, EIRQ_PRIO2_RST);
      chk(prio, 8'h00);
      $display("Reset values done");
      wr(EIRQ_PRIO2_ADDR, 8'h00, 8'ha5);
      #1 chk(prio, 8'ha5);
      rd(EIRQ_PRIO2_ADDR, 8'h0f, 8'ha5);
      wr(EIRQ_PRIO2_ADDR, 8'h0f, 8'h5a);
      #1 chk(prio, 8'h5a);
      rd(EIRQ_PRIO2_ADDR, 8'h03, 8'h5a);
      $display("Priority register done");
      wr(EIRQ_CFG_ADDR, 8'h00, 8'hff);
      rd(EIRQ_CFG_ADDR, EIRQ_CFG_PAGE, 8'h00);
      wr(EIRQ_CFG_ADDR, EIRQ_CFG_PAGE, 8'hb6);
      rd(EIRQ_CFG_ADDR, EIRQ_CFG_PAGE, 8'hb6);
      rd(8'h55, EIRQ_CFG_PAGE, 8'h00);
      $display("Configuration register done");
      for (int i = 0; i < 8; i++)
         level_case(1'b0, i[2:0], 1'b1);
      for (int i = 0; i < 8; i++)
         level_case(1'b1, i[2:0], 1'b0);
      $display("Level mode done");
      edge_case(1'b0, 3'h3, 1'b1);
      edge_case(1'b1, 3'h5, 1'b0);
      $display("Edge mode done");
      wrap_up();
   end
endmodule
